/* File: verilog/hcdf_pkg.sv */
// hcdf_pkg: constants, types and decode functions for the chopping controller
//
// Functional notes
// - drive winding until trip comparator fires
// - fast decay reverses bridge, off near zero
// - slow decay turns both low sides on
// - four decay modes from mode field
// - mixed: fast for set time, then slow
// - auto: trip at blank end gives fast
// - auto fast ends after trip clears, blank
// - off time expiry starts next drive cycle
// - auto: below trip, drive then slow decay
// - blanking 500 ns plus 20 ns steps
// - blanking is minimum drive on time
// - auto fast decay ignores trip during blank
// - four source levels, sink about double
// - peak gate current after each change
// - pull low side low at high-side turn-on
// - digital dead time between partner switches
// - gate drive time never stretches chopping
// - deglitched overcurrent disables bridge, flags fault
// - overcurrent latched until cleared or reset
// - gate drive fault disables bridge, flags
// - gate fault latched until cleared or reset
// - overtemperature stops all, self clears
// - off time steps of 525 ns
// - dead time codes 410/460/670/880 ns
// - undervoltage stops all, self clears
`default_nettype none
package hcdf_pkg;
   // ****************************************
   // clock and timing
   // ****************************************
   localparam int CLK_HZ         = 20_000_000;
   localparam int CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;
   localparam int BLANK_MIN_NS   = 500;
   localparam int BLANK_MAX_NS   = 5140;
   localparam int BLANK_STEP_NS  = 20;
   localparam int BLANK_MAX_CODE = (BLANK_MAX_NS - BLANK_MIN_NS) / BLANK_STEP_NS;
   localparam int OFF_STEP_NS    = 525;
   localparam int FAST_STEP_NS   = 525;
   localparam int DEAD_NS [4]    = '{410, 460, 670, 880};
   localparam int PEAK_NS [4]    = '{250, 500, 1000, 2000};
   localparam int DEGL_NS [4]    = '{1000, 2000, 4000, 8000};
   localparam int BLANK_W        = 7;
   localparam int OFF_W          = 12;
   localparam int DEAD_W         = 5;
   localparam int PEAK_W         = 6;
   localparam int DEGL_W         = 8;
   localparam int NBR            = 2;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {HB_OFF, HB_HIGH, HB_LOW} hcdf_hb_cmd_t;
   typedef enum logic [1:0] {DM_SLOW, DM_FAST, DM_MIXED, DM_AUTO} hcdf_decay_t;
   typedef enum logic [1:0] {CH_IDLE, CH_DRIVE, CH_FAST, CH_SLOW} hcdf_chop_t;
   typedef struct packed {
      logic hs;
      logic ls;
      logic peak;
      logic ls_pull;
   } hcdf_gate_t;
   typedef struct packed {
      logic [1:0] in1;
      logic [1:0] in2;
      logic [1:0] trip;
      logic [1:0] zero;
      logic [7:0] vds;
      logic [1:0] gfault;
      logic       otemp;
      logic       uvolt;
   } hcdf_pins_t;

   // ****************************************
   // decode functions (terminal counts)
   // ****************************************
   function automatic int ceil_cyc(input int ns);
      return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   endfunction

   function automatic logic [BLANK_W-1:0] blank_tc(input logic [7:0] code);
      int c;
      c = (int'(code) > BLANK_MAX_CODE) ? BLANK_MAX_CODE : int'(code);
      return BLANK_W'(ceil_cyc(BLANK_MIN_NS + c * BLANK_STEP_NS) - 1);
   endfunction

   function automatic logic [OFF_W-1:0] step_tc(input logic [7:0] code, input int step_ns);
      return OFF_W'(ceil_cyc((int'(code) + 1) * step_ns) - 1);
   endfunction
endpackage
`default_nettype wire

/* File: verilog/hcdf_half_gate.sv */
// hcdf_half_gate: one half-bridge gate sequencer with dead time and peak drive
`timescale 1ns/1ps
`default_nettype none
module hcdf_half_gate (
   input  wire logic                              clk_in,
   input  wire logic                              rstn_in,
   input  wire hcdf_pkg::hcdf_hb_cmd_t            cmd_in,
   input  wire logic [hcdf_pkg::DEAD_W-1:0]       dead_tc_in,
   input  wire logic [hcdf_pkg::PEAK_W-1:0]       peak_cyc_in,
   output var  hcdf_pkg::hcdf_gate_t              gate_out
);
   hcdf_pkg::hcdf_gate_t              gate;
   hcdf_pkg::hcdf_gate_t              next_gate;
   logic [hcdf_pkg::DEAD_W-1:0]       dead_cnt;
   logic [hcdf_pkg::DEAD_W-1:0]       next_dead_cnt;
   logic [hcdf_pkg::PEAK_W-1:0]       peak_cnt;
   logic [hcdf_pkg::PEAK_W-1:0]       next_peak_cnt;

   localparam logic [hcdf_pkg::DEAD_W-1:0] DEAD_ONE = 1;
   localparam logic [hcdf_pkg::PEAK_W-1:0] PEAK_ONE = 1;

   // ****************************************
   // gate sequencing
   // ****************************************
   // turn-off is immediate; turn-on waits for partner off and dead time spent
   always_comb begin
      next_gate     = gate;
      next_dead_cnt = (dead_cnt != '0) ? dead_cnt - DEAD_ONE : '0;
      next_peak_cnt = (peak_cnt != '0) ? peak_cnt - PEAK_ONE : '0;
      unique case (cmd_in)
         hcdf_pkg::HB_HIGH: begin
            next_gate.ls = 1'b0;
            next_gate.hs = gate.hs | (~gate.ls & (dead_cnt == '0));
         end
         hcdf_pkg::HB_LOW: begin
            next_gate.hs = 1'b0;
            next_gate.ls = gate.ls | (~gate.hs & (dead_cnt == '0));
         end
         default: begin
            next_gate.hs = 1'b0;
            next_gate.ls = 1'b0;
         end
      endcase
      if ((gate.hs & ~next_gate.hs) | (gate.ls & ~next_gate.ls)) begin
         next_dead_cnt = dead_tc_in;
      end
      // peak window runs beside the chopping timing, never delaying it
      if ((next_gate.hs != gate.hs) | (next_gate.ls != gate.ls)) begin
         next_peak_cnt = peak_cyc_in;
      end
      next_gate.peak    = (next_peak_cnt != '0);
      next_gate.ls_pull = next_gate.hs & next_gate.peak & (~gate.hs | gate.ls_pull);
   end

   // gate state registers
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         gate     <= '0;
         dead_cnt <= '0;
         peak_cnt <= '0;
      end else begin
         gate     <= next_gate;
         dead_cnt <= next_dead_cnt;
         peak_cnt <= next_peak_cnt;
      end
   end

   assign gate_out = gate;
endmodule // hcdf_half_gate
`default_nettype wire

/* File: verilog/hcdf_ctrl.sv */
// hcdf_ctrl: dual H-bridge fixed-off-time chopper with decay modes and faults
`timescale 1ns/1ps
`default_nettype none
module hcdf_ctrl (
   input  wire logic       CLK_SYS_IN,
   input  wire logic       RSTN_IN,
   input  wire logic [1:0] BRIDGE_IN1_IN,
   input  wire logic [1:0] BRIDGE_IN2_IN,
   input  wire logic       ENABLE_IN,
   input  wire logic [1:0] DECAY_MODE_SEL_IN,
   input  wire logic [7:0] FAST_DECAY_DURATION_IN,
   input  wire logic [7:0] BLANK_INTERVAL_IN,
   input  wire logic [7:0] OFF_TIME_FIELD_IN,
   input  wire logic [1:0] DEAD_TIME_SEL_IN,
   input  wire logic [1:0] GATE_PEAK_CURRENT_SEL_IN,
   input  wire logic [1:0] GATE_PEAK_DURATION_IN,
   input  wire logic [1:0] OVERCURRENT_THRESHOLD_SEL_IN,
   input  wire logic [1:0] OVERCURRENT_DEGLITCH_SEL_IN,
   input  wire logic [1:0] TRIP_IN,
   input  wire logic [1:0] ZERO_CURRENT_IN,
   input  wire logic [7:0] VDS_OVER_IN,
   input  wire logic [1:0] GATE_DRIVE_FAULT_IN,
   input  wire logic       THERMAL_SHUTDOWN_IN,
   input  wire logic       UNDERVOLTAGE_IN,
   input  wire logic [1:0] OVERCURRENT_CLEAR_IN,
   input  wire logic [1:0] GATE_FAULT_CLEAR_IN,
   output var  logic [3:0] GATE_HS_OUT,
   output var  logic [3:0] GATE_LS_OUT,
   output var  logic [3:0] GATE_PEAK_OUT,
   output var  logic [3:0] LS_PULL_LOW_OUT,
   output var  logic [1:0] GATE_SOURCE_CURRENT_SEL_OUT,
   output var  logic [1:0] GATE_SINK_CURRENT_SEL_OUT,
   output var  logic [1:0] OVERCURRENT_THRESHOLD_SEL_OUT,
   output var  logic [1:0] BRIDGE_OVERCURRENT_FLAG_OUT,
   output var  logic [1:0] BRIDGE_GATE_FAULT_FLAG_OUT,
   output var  logic       OVERTEMP_FLAG_OUT,
   output var  logic       UNDERVOLTAGE_FLAG_OUT,
   output var  logic       FAULT_N_OUT
);
   localparam int NBR = hcdf_pkg::NBR;

   // ****************************************
   // pin synchroniser
   // ****************************************
   hcdf_pkg::hcdf_pins_t pins_raw;
   hcdf_pkg::hcdf_pins_t pins_meta;
   hcdf_pkg::hcdf_pins_t pins;

   assign pins_raw = '{in1: BRIDGE_IN1_IN, in2: BRIDGE_IN2_IN, trip: TRIP_IN,
                       zero: ZERO_CURRENT_IN, vds: VDS_OVER_IN,
                       gfault: GATE_DRIVE_FAULT_IN, otemp: THERMAL_SHUTDOWN_IN,
                       uvolt: UNDERVOLTAGE_IN};

   // two flops; only the second stage feeds logic
   always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         pins_meta <= '0;
         pins      <= '0;
      end else begin
         pins_meta <= pins_raw;
         pins      <= pins_meta;
      end
   end

   // ****************************************
   // configuration decode
   // ****************************************
   logic [hcdf_pkg::DEAD_W-1:0] dead_tc;
   logic [hcdf_pkg::DEAD_W-1:0] next_dead_tc;
   logic [hcdf_pkg::PEAK_W-1:0] peak_cyc;
   logic [hcdf_pkg::PEAK_W-1:0] next_peak_cyc;
   logic [hcdf_pkg::DEGL_W-1:0] degl_tc;
   logic [hcdf_pkg::DEGL_W-1:0] next_degl_tc;
   logic [1:0]                  src_sel;
   logic [1:0]                  sink_sel;
   logic [1:0]                  octh_sel;
   hcdf_pkg::hcdf_decay_t       mode;

   assign mode = hcdf_pkg::hcdf_decay_t'(DECAY_MODE_SEL_IN);

   // dead, peak and deglitch fields turned into cycle counts once, then registered
   always_comb begin
      next_dead_tc  = hcdf_pkg::DEAD_W'(hcdf_pkg::ceil_cyc(
                         hcdf_pkg::DEAD_NS[DEAD_TIME_SEL_IN]) - 1);
      next_peak_cyc = hcdf_pkg::PEAK_W'(hcdf_pkg::ceil_cyc(
                         hcdf_pkg::PEAK_NS[GATE_PEAK_DURATION_IN]));
      next_degl_tc  = hcdf_pkg::DEGL_W'(hcdf_pkg::ceil_cyc(
                         hcdf_pkg::DEGL_NS[OVERCURRENT_DEGLITCH_SEL_IN]) - 1);
   end

   // sink code equals source code: the sink stage runs at twice the level
   always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         dead_tc  <= '0;
         peak_cyc <= '0;
         degl_tc  <= '0;
         src_sel  <= '0;
         sink_sel <= '0;
         octh_sel <= '0;
      end else begin
         dead_tc  <= next_dead_tc;
         peak_cyc <= next_peak_cyc;
         degl_tc  <= next_degl_tc;
         src_sel  <= GATE_PEAK_CURRENT_SEL_IN;
         sink_sel <= GATE_PEAK_CURRENT_SEL_IN;
         octh_sel <= OVERCURRENT_THRESHOLD_SEL_IN;
      end
   end

   // ****************************************
   // global faults
   // ****************************************
   logic [NBR-1:0] ocp_v;
   logic [NBR-1:0] pdf_v;
   logic           overtemp_flag;
   logic           undervoltage_flag;
   logic           fault_n;
   logic           next_fault_n;

   // fault line follows the flags one cycle late, so it lifts with the brake gates and a cycle before the drive gates turn back on
   always_comb begin
      next_fault_n = ~(|ocp_v | |pdf_v | overtemp_flag | undervoltage_flag);
   end

   // thermal and supply flags track the sensed level and clear by themselves
   always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         overtemp_flag     <= 1'b0;
         undervoltage_flag    <= 1'b0;
         fault_n <= 1'b1;
      end else begin
         overtemp_flag     <= pins.otemp;
         undervoltage_flag    <= pins.uvolt;
         fault_n <= next_fault_n;
      end
   end

   // ****************************************
   // per-bridge chopper and latched faults
   // ****************************************
   for (genvar b = 0; b < NBR; b++) begin : g_br
      hcdf_pkg::hcdf_chop_t          st;
      hcdf_pkg::hcdf_chop_t          next_st;
      logic [hcdf_pkg::BLANK_W-1:0]  blank_cnt;
      logic [hcdf_pkg::BLANK_W-1:0]  next_blank_cnt;
      logic [hcdf_pkg::OFF_W-1:0]    off_cnt;
      logic [hcdf_pkg::OFF_W-1:0]    next_off_cnt;
      logic [hcdf_pkg::OFF_W-1:0]    fast_cnt;
      logic [hcdf_pkg::OFF_W-1:0]    next_fast_cnt;
      logic                          sampled;
      logic                          next_sampled;
      logic                          zoff;
      logic                          next_zoff;
      logic                          dir;
      logic                          next_dir;
      logic                          overcurrent_event;
      logic                          next_ocp;
      logic                          gate_drive_fault;
      logic                          next_pdf;
      logic [hcdf_pkg::DEGL_W-1:0]   degl_cnt;
      logic [hcdf_pkg::DEGL_W-1:0]   next_degl_cnt;
      logic                          bridge_ok;
      logic                          run;
      logic                          trip;
      logic                          over;
      hcdf_pkg::hcdf_hb_cmd_t        cmd [2];
      hcdf_pkg::hcdf_gate_t          gate [2];

      assign bridge_ok = ENABLE_IN & ~overcurrent_event & ~gate_drive_fault & ~overtemp_flag & ~undervoltage_flag;
      assign run       = bridge_ok & (pins.in1[b] ^ pins.in2[b]);
      assign trip      = pins.trip[b];

      // chopping sequence: drive, then decay for the fixed off time
      always_comb begin
         next_st        = st;
         next_blank_cnt = (blank_cnt != '0) ? blank_cnt - 1'b1 : '0;
         next_off_cnt   = (off_cnt != '0) ? off_cnt - 1'b1 : '0;
         next_fast_cnt  = (fast_cnt != '0) ? fast_cnt - 1'b1 : '0;
         next_sampled   = sampled;
         next_zoff      = zoff;
         next_dir       = dir;
         unique case (st)
            hcdf_pkg::CH_IDLE: begin
               if (run) begin
                  next_st        = hcdf_pkg::CH_DRIVE;
                  next_blank_cnt = hcdf_pkg::blank_tc(BLANK_INTERVAL_IN);
                  next_sampled   = 1'b0;
                  next_dir       = pins.in1[b];
               end
            end
            hcdf_pkg::CH_DRIVE: begin
               // comparator ignored until the blanking count is spent
               if (blank_cnt == '0) begin
                  next_sampled = 1'b1;
                  if (trip) begin
                     next_off_cnt = hcdf_pkg::step_tc(OFF_TIME_FIELD_IN,
                                                      hcdf_pkg::OFF_STEP_NS);
                     next_zoff    = 1'b0;
                     if ((mode == hcdf_pkg::DM_AUTO) && !sampled) begin
                        next_st        = hcdf_pkg::CH_FAST;
                        next_blank_cnt = hcdf_pkg::blank_tc(BLANK_INTERVAL_IN);
                     end else if ((mode == hcdf_pkg::DM_SLOW) ||
                                  (mode == hcdf_pkg::DM_AUTO)) begin
                        next_st = hcdf_pkg::CH_SLOW;
                     end else begin
                        next_st       = hcdf_pkg::CH_FAST;
                        next_fast_cnt = hcdf_pkg::step_tc(FAST_DECAY_DURATION_IN,
                                                          hcdf_pkg::FAST_STEP_NS);
                     end
                  end
               end
            end
            hcdf_pkg::CH_FAST: begin
               if (pins.zero[b]) begin
                  next_zoff = 1'b1;
               end
               if (off_cnt == '0) begin
                  next_st        = hcdf_pkg::CH_DRIVE;
                  next_blank_cnt = hcdf_pkg::blank_tc(BLANK_INTERVAL_IN);
                  next_sampled   = 1'b0;
               end else if ((mode == hcdf_pkg::DM_MIXED) && (fast_cnt == '0)) begin
                  next_st = hcdf_pkg::CH_SLOW;
               end else if ((mode == hcdf_pkg::DM_AUTO) && (blank_cnt == '0) && !trip) begin
                  next_st = hcdf_pkg::CH_SLOW;
               end
            end
            hcdf_pkg::CH_SLOW: begin
               if (off_cnt == '0) begin
                  next_st        = hcdf_pkg::CH_DRIVE;
                  next_blank_cnt = hcdf_pkg::blank_tc(BLANK_INTERVAL_IN);
                  next_sampled   = 1'b0;
               end
            end
         endcase
         // stop, fault or direction change drops back to idle
         if ((st != hcdf_pkg::CH_IDLE) && (!run || (pins.in1[b] != dir))) begin
            next_st = hcdf_pkg::CH_IDLE;
         end
      end

      // half-bridge commands; out1 is half 0, out2 is half 1
      always_comb begin
         cmd[0] = hcdf_pkg::HB_OFF;
         cmd[1] = hcdf_pkg::HB_OFF;
         unique case (st)
            hcdf_pkg::CH_DRIVE: begin
               cmd[0] = dir ? hcdf_pkg::HB_HIGH : hcdf_pkg::HB_LOW;
               cmd[1] = dir ? hcdf_pkg::HB_LOW : hcdf_pkg::HB_HIGH;
            end
            hcdf_pkg::CH_FAST: begin
               if (!zoff) begin
                  cmd[0] = dir ? hcdf_pkg::HB_LOW : hcdf_pkg::HB_HIGH;
                  cmd[1] = dir ? hcdf_pkg::HB_HIGH : hcdf_pkg::HB_LOW;
               end
            end
            hcdf_pkg::CH_SLOW: begin
               cmd[0] = hcdf_pkg::HB_LOW;
               cmd[1] = hcdf_pkg::HB_LOW;
            end
            hcdf_pkg::CH_IDLE: begin
               if (pins.in1[b] & pins.in2[b]) begin
                  cmd[0] = hcdf_pkg::HB_LOW; // brake
                  cmd[1] = hcdf_pkg::HB_LOW;
               end
            end
         endcase
         if (!bridge_ok) begin
            cmd[0] = hcdf_pkg::HB_OFF;
            cmd[1] = hcdf_pkg::HB_OFF;
         end
      end

      // deglitched drop monitor on driven transistors; set beats clear
      always_comb begin
         over = |(pins.vds[b*4 +: 4] &
                  {gate[1].ls, gate[1].hs, gate[0].ls, gate[0].hs});
         next_degl_cnt = '0;
         if (over && (degl_cnt != degl_tc)) begin
            next_degl_cnt = degl_cnt + 1'b1;
         end else if (over) begin
            next_degl_cnt = degl_cnt;
         end
         next_ocp = (overcurrent_event & ~OVERCURRENT_CLEAR_IN[b]) | (over & (degl_cnt == degl_tc));
         next_pdf = (gate_drive_fault & ~GATE_FAULT_CLEAR_IN[b]) | pins.gfault[b];
      end

      // chopper and fault registers
      always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
         if (!RSTN_IN) begin
            st        <= hcdf_pkg::CH_IDLE;
            blank_cnt <= '0;
            off_cnt   <= '0;
            fast_cnt  <= '0;
            sampled   <= 1'b0;
            zoff      <= 1'b0;
            dir       <= 1'b0;
            overcurrent_event       <= 1'b0;
            gate_drive_fault       <= 1'b0;
            degl_cnt  <= '0;
         end else begin
            st        <= next_st;
            blank_cnt <= next_blank_cnt;
            off_cnt   <= next_off_cnt;
            fast_cnt  <= next_fast_cnt;
            sampled   <= next_sampled;
            zoff      <= next_zoff;
            dir       <= next_dir;
            overcurrent_event       <= next_ocp;
            gate_drive_fault       <= next_pdf;
            degl_cnt  <= next_degl_cnt;
         end
      end

      // gate sequencers for both halves
      for (genvar h = 0; h < 2; h++) begin : g_half
         hcdf_half_gate u_half (
            .clk_in      (CLK_SYS_IN),
            .rstn_in     (RSTN_IN),
            .cmd_in      (cmd[h]),
            .dead_tc_in  (dead_tc),
            .peak_cyc_in (peak_cyc),
            .gate_out    (gate[h])
         );
         assign GATE_HS_OUT[b*2+h]     = gate[h].hs;
         assign GATE_LS_OUT[b*2+h]     = gate[h].ls;
         assign GATE_PEAK_OUT[b*2+h]   = gate[h].peak;
         assign LS_PULL_LOW_OUT[b*2+h] = gate[h].ls_pull;
      end

      assign ocp_v[b] = overcurrent_event;
      assign pdf_v[b] = gate_drive_fault;
   end

   // ****************************************
   // status outputs
   // ****************************************
   assign GATE_SOURCE_CURRENT_SEL_OUT   = src_sel;
   assign GATE_SINK_CURRENT_SEL_OUT     = sink_sel;
   assign OVERCURRENT_THRESHOLD_SEL_OUT = octh_sel;
   assign BRIDGE_OVERCURRENT_FLAG_OUT   = ocp_v;
   assign BRIDGE_GATE_FAULT_FLAG_OUT    = pdf_v;
   assign OVERTEMP_FLAG_OUT             = overtemp_flag;
   assign UNDERVOLTAGE_FLAG_OUT         = undervoltage_flag;
   assign FAULT_N_OUT                   = fault_n;
endmodule // hcdf_ctrl
`default_nettype wire

/* File: verif/hcdf_ctrl_monitor.sv */
// hcdf_ctrl_monitor: port assertions for the chopping controller
`timescale 1ns/1ps
`default_nettype none
module hcdf_ctrl_monitor (
   input  wire logic       CLK_SYS_IN,
   input  wire logic       RSTN_IN,
   input  wire logic [1:0] OVERCURRENT_CLEAR_IN,
   input  wire logic [3:0] GATE_HS_OUT,
   input  wire logic [3:0] GATE_LS_OUT,
   input  wire logic [3:0] GATE_PEAK_OUT,
   input  wire logic [3:0] LS_PULL_LOW_OUT,
   input  wire logic [1:0] BRIDGE_OVERCURRENT_FLAG_OUT,
   input  wire logic [1:0] BRIDGE_GATE_FAULT_FLAG_OUT,
   input  wire logic       OVERTEMP_FLAG_OUT,
   input  wire logic       UNDERVOLTAGE_FLAG_OUT,
   input  wire logic       FAULT_N_OUT
);
   logic [5:0] flags;
   logic [3:0] on;
   // ****
   // fault and gate relations
   // ****
   assign flags = {BRIDGE_OVERCURRENT_FLAG_OUT, BRIDGE_GATE_FAULT_FLAG_OUT,
                   OVERTEMP_FLAG_OUT, UNDERVOLTAGE_FLAG_OUT};
   assign on = GATE_HS_OUT | GATE_LS_OUT;
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (!RSTN_IN);
   chk_fault_low: assert property (|flags |=> !FAULT_N_OUT)
      else $error("fault output not low");
   chk_fault_release: assert property (!(|flags) |=> FAULT_N_OUT)
      else $error("fault output not released");
   chk_ocp_off: assert property (BRIDGE_OVERCURRENT_FLAG_OUT[0] [*2] |-> on[1:0] == 2'h0)
      else $error("bridge on after overcurrent");
   chk_gdf_off: assert property (BRIDGE_GATE_FAULT_FLAG_OUT[1] [*2] |-> on[3:2] == 2'h0)
      else $error("bridge on after gate fault");
   chk_temp_off: assert property ((OVERTEMP_FLAG_OUT || UNDERVOLTAGE_FLAG_OUT) [*2] |-> on == 4'h0)
      else $error("gates on during shutdown");
   chk_no_shoot: assert property (!(|(GATE_HS_OUT & GATE_LS_OUT)))
      else $error("both switches of a half on");
   chk_dead_gap: assert property ($fell(GATE_LS_OUT[0]) |-> !GATE_HS_OUT[0] [*8])
      else $error("dead time too short");
   chk_peak_pull: assert property ($rose(GATE_HS_OUT[0]) |-> GATE_PEAK_OUT[0] && LS_PULL_LOW_OUT[0])
      else $error("no peak drive or pull low at turn on");
   chk_ocp_latch: assert property ($fell(BRIDGE_OVERCURRENT_FLAG_OUT[0]) |-> $past(OVERCURRENT_CLEAR_IN[0]))
      else $error("overcurrent flag fell without clear");
endmodule // hcdf_ctrl_monitor
`default_nettype wire

/* File: verif/hcdf_bridge_model.sv */
// hcdf_bridge_model: behavioural winding current of two external bridges
`timescale 1ns/1ps
`default_nettype none
module hcdf_bridge_model (
   input  wire logic       clk_in,
   input  wire logic [3:0] hs_in,
   input  wire logic [3:0] ls_in,
   output var  logic [1:0] trip_out,
   output var  logic [1:0] zero_out
);
   int cur [2] = '{0, 0};
   // ****
   // winding current and comparators
   // ****
   // current rises when driven forward, falls fast in reverse, slowly otherwise
   always @(posedge clk_in) begin
      for (int b = 0; b < 2; b++) begin
         if (hs_in[b*2] && ls_in[b*2+1]) cur[b] <= cur[b] + 8;
         else if (hs_in[b*2+1] && ls_in[b*2]) cur[b] <= (cur[b] > 8) ? cur[b] - 8 : 0;
         else if (cur[b] > 0) cur[b] <= cur[b] - 1;
      end
   end
   // comparator outputs seen at the sense pins
   always_comb begin
      for (int b = 0; b < 2; b++) begin
         trip_out[b] = cur[b] >= 40;
         zero_out[b] = cur[b] < 4;
      end
   end
endmodule // hcdf_bridge_model
`default_nettype wire

/* File: verif/hcdf_ctrl_tb.sv */
// hcdf_ctrl_tb: self-checking bench for the chopping controller
`timescale 1ns/1ps
`default_nettype none
module hcdf_ctrl_tb;
   logic       clk, rstn, en, ot, uv, rev, slo, otf, uvf, fault_n;
   logic [1:0] in1, in2, mode, dsel, psel, pdur, thr, deg, trip, zero, gdf, oclr, gclr;
   logic [1:0] src, snk, thro, ocf, gff;
   logic [7:0] fdur, blank, off, vds;
   logic [3:0] hs, ls, pk, pull;
   int         err_count, n_compared, n, r;
   hcdf_ctrl u_dut (.CLK_SYS_IN(clk), .RSTN_IN(rstn), .BRIDGE_IN1_IN(in1),
      .BRIDGE_IN2_IN(in2), .ENABLE_IN(en), .DECAY_MODE_SEL_IN(mode),
      .FAST_DECAY_DURATION_IN(fdur), .BLANK_INTERVAL_IN(blank), .OFF_TIME_FIELD_IN(off),
      .DEAD_TIME_SEL_IN(dsel), .GATE_PEAK_CURRENT_SEL_IN(psel), .GATE_PEAK_DURATION_IN(pdur),
      .OVERCURRENT_THRESHOLD_SEL_IN(thr), .OVERCURRENT_DEGLITCH_SEL_IN(deg), .TRIP_IN(trip),
      .ZERO_CURRENT_IN(zero), .VDS_OVER_IN(vds), .GATE_DRIVE_FAULT_IN(gdf),
      .THERMAL_SHUTDOWN_IN(ot), .UNDERVOLTAGE_IN(uv), .OVERCURRENT_CLEAR_IN(oclr),
      .GATE_FAULT_CLEAR_IN(gclr), .GATE_HS_OUT(hs), .GATE_LS_OUT(ls), .GATE_PEAK_OUT(pk),
      .LS_PULL_LOW_OUT(pull), .GATE_SOURCE_CURRENT_SEL_OUT(src),
      .GATE_SINK_CURRENT_SEL_OUT(snk), .OVERCURRENT_THRESHOLD_SEL_OUT(thro),
      .BRIDGE_OVERCURRENT_FLAG_OUT(ocf), .BRIDGE_GATE_FAULT_FLAG_OUT(gff),
      .OVERTEMP_FLAG_OUT(otf), .UNDERVOLTAGE_FLAG_OUT(uvf), .FAULT_N_OUT(fault_n));
   hcdf_bridge_model u_mot (.clk_in(clk), .hs_in(hs), .ls_in(ls), .trip_out(trip),
      .zero_out(zero));
   // ****
   // helpers
   // ****
   // 20 MHz core clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // note reversed drive and both low sides on, bridge 0
   always @(posedge clk) begin
      if (hs[1] && ls[0]) rev = 1'b1;
      if (ls[0] && ls[1]) slo = 1'b1;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #2;
   endtask
   // count cycles until high side 0 reaches v, bounded
   task automatic wait_hs(input logic v, output int c);
      c = 0;
      while (hs[0] !== v) begin
         step(1);
         c++;
         if (c > 3000) begin
            check(0, 1);
            test_done;
         end
      end
   endtask
   // high side off span in slow decay: off time plus dead time
   function automatic int off_gap(input logic [7:0] c, input logic [1:0] d);
      int dns [4] = '{410, 460, 670, 880};
      return ((int'(c) + 1) * 525 + 49) / 50 + (dns[d] + 49) / 50;
   endfunction
   // ****
   // main sequence
   // ****
   initial begin
      {rstn, en, ot, uv, in1, in2, mode, gdf, oclr, gclr, vds, deg} = '0;
      r = $urandom(32'h031446B0);
      fdur = 8'(4 + $urandom % 4);
      blank = 8'(60 + $urandom % 40);
      off = 8'(10 + $urandom % 6);
      dsel = 2'($urandom);
      psel = 2'($urandom);
      pdur = 2'($urandom);
      thr = 2'($urandom);
      step(4);
      rstn = 1'b1;
      step(2);
      check(src, psel);
      check(snk, psel);
      check(thro, thr);
      en = 1'b1;
      in1 = 2'h1;
      // every decay mode in turn, forward on bridge 0
      for (int m = 0; m < 4; m++) begin
         mode = 2'(m);
         step(400);
         wait_hs(1, n);
         wait_hs(0, n);
         {rev, slo} = 2'h0;
         wait_hs(1, n);
         if (m == 0) check(32'(n >= off_gap(off, dsel) - 2 && n <= off_gap(off, dsel) + 2), 1);
         check(rev, m != 0);
         check(slo, m != 1);
      end
      // overcurrent on a braking bridge, latched until cleared
      in2 = 2'h1;
      vds = 8'hFF;
      for (int k = 0; k < 400 && ocf[0] !== 1'b1; k++) step(1);
      check(ocf, 2'h1);
      step(2);
      check(fault_n, 1'b0);
      vds = 8'h00;
      step(20);
      check(ocf, 2'h1);
      oclr = 2'h1;
      step(1);
      oclr = 2'h0;
      step(3);
      check({ocf, fault_n}, 3'h1);
      // gate drive fault on bridge 1
      gdf = 2'h2;
      step(3);
      gdf = 2'h0;
      step(6);
      check({gff, fault_n}, 3'h4);
      gclr = 2'h2;
      step(1);
      gclr = 2'h0;
      step(3);
      check({gff, fault_n}, 3'h1);
      // thermal then supply shutdown, both self clearing
      for (int i = 0; i < 2; i++) begin
         {uv, ot} = 2'(i + 1);
         step(6);
         check({uvf, otf, fault_n, hs | ls}, {2'(i + 1), 5'h00});
         {uv, ot} = 2'h0;
         step(6);
         check({uvf, otf, fault_n}, 3'h1);
      end
      // reset in mid-run
      rstn = 1'b0;
      step(1);
      check({fault_n, hs, ocf}, 7'h40);
      rstn = 1'b1;
      step(2);
      check({fault_n, hs}, 5'h10);
      test_done;
   end
endmodule // hcdf_ctrl_tb
bind hcdf_ctrl hcdf_ctrl_monitor u_mon (.*);
`default_nettype wire
